// *** spm_port.sv ***
// Byte-wide serial peripheral port, master or slave, with Wishbone registers
//
// Notes on behaviour
// - Slave with select low is active; data out driven only if configured.
// - Slave with select high keeps all pins input and accepts no data.
// - Select rising in slave resets bit counter and drops partial bits.
// - Master with select as output: plain output, no engine effect.
// - Master with select input low: drop master bit, become slave.
// - That forced switch also sets the done flag, raising interrupt.
// - Drive and sample on opposite edges in all four modes.
// - Polarity bit 3 sets clock idle level and leading edge direction.
// - Phase bit 2 picks sampling on leading or trailing edge.
// - Order bit 5 sends least significant bit first when one.
// - Enable bit 6 must be one for any transfer.
// - Interrupt enable bit 7 requests interrupt with done flag and global enable.
// - Master rate codes divide by 4,16,64,128, or 2,8,32,64 doubled.
// - Rate bits ignored in slave role.
// - Done flag at status 7; cleared by vector or status read then data access.
// - Collision flag at status 6 set on data write during transfer.
// - Status bits 5 to 1 read zero.
// - Double rate bit at status 0 doubles master clock.
// - Data write starts transmission; data read returns receive buffer.
// - Master shifts eight bits, stops, sets done flag, keeps byte.
// - Single buffered transmit; double buffered receive, overwrite on overrun.
`timescale 1ns/10ps

module spm_port
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire spm_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Interrupt
  input wire logic gie_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  // Serial pins
  input wire spm_pins_t pin_i,
  output spm_pins_t pin_o,
  output spm_pins_t pin_oe_o
);

  spm_state_t s;
  spm_state_t next_s;

  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic en;
    logic master_select;
    logic cpol;
    logic cpha;
    logic lsb;
    logic acc;
    logic wr;
    logic rd;
    logic busy;
    logic slv_act;
    logic ledge;
    logic tedge;
    logic samp;
    logic setup;
    logic in_bit;
    logic [1:0] rate;
    logic [7:0] div;
    logic [6:0] half_m1;
    logic [3:0] cnt;
    en = s.ctrl[CTRL_EN];
    master_select = s.ctrl[CTRL_MASTER_SELECT];
    cpol = s.ctrl[CTRL_CPOL];
    cpha = s.ctrl[CTRL_CPHA];
    lsb = s.ctrl[CTRL_LSB];
    next_s = s;
    next_s.ack = 1'b0;
    // Two-flop synchronisers, third stage for edge detection
    next_s.ss_s1 = pin_i.ss;
    next_s.ss_s2 = s.ss_s1;
    next_s.ss_s3 = s.ss_s2;
    next_s.sck_s1 = pin_i.sck;
    next_s.sck_s2 = s.sck_s1;
    next_s.sck_s3 = s.sck_s2;

    // ========================================================================
    // Bus access, one wait-free acknowledge per request
    acc = wb_i.cyc & wb_i.stb & ~s.ack;
    wr = acc & wb_i.we & wb_i.sel[0];
    rd = acc & ~wb_i.we;
    busy = (s.eng == SPM_RUN) | (s.bitcnt != 4'h0);
    next_s.ack = acc;
    if (acc) begin
      next_s.dat = 8'h00;
    end
    if (rd) begin
      unique case (wb_i.adr)
        ADR_CTRL: next_s.dat = s.ctrl;
        ADR_STAT: next_s.dat = {s.done_flag, s.write_collision_flag_flag, 5'h00, s.dbl};
        ADR_DATA: next_s.dat = s.rxbuf;
        ADR_PINS: next_s.dat = {3'h0, s.pdir};
        default: next_s.dat = 8'h00;
      endcase
    end
    // Status read arms the clear; the next data access performs it
    if (rd && wb_i.adr == ADR_STAT) begin
      next_s.done_seen = s.done_flag;
      next_s.write_collision_flag_seen = s.write_collision_flag_flag;
    end
    if (acc && wb_i.adr == ADR_DATA) begin
      if (s.done_seen || s.write_collision_flag_seen) begin
        next_s.done_flag = 1'b0;
        next_s.write_collision_flag_flag = 1'b0;
      end
      next_s.done_seen = 1'b0;
      next_s.write_collision_flag_seen = 1'b0;
    end
    if (irq_ack_i) begin
      next_s.done_flag = 1'b0;
    end
    if (wr) begin
      unique case (wb_i.adr)
        ADR_CTRL: next_s.ctrl = wb_i.dat[7:0];
        ADR_STAT: next_s.dbl = wb_i.dat[STAT_DBL];
        ADR_PINS: next_s.pdir = wb_i.dat[4:0];
        ADR_DATA: begin
          if (!busy) begin
            // Transmit is single buffered: the byte goes straight to the shifter
            next_s.sr = wb_i.dat[7:0];
            next_s.dout = out_bit(wb_i.dat[7:0], lsb);
            if (en && master_select) begin
              next_s.eng = SPM_RUN;
              next_s.divcnt = 7'h00;
            end
          end
        end
        default: ;
      endcase
    end

    // ========================================================================
    // Serial engine
    rate = {s.ctrl[CTRL_RATE_HI], s.ctrl[CTRL_RATE_LO]};
    div = s.dbl ? DIV_DBL[rate] : DIV_NORM[rate];
    half_m1 = 7'(div[7:1] - 7'h01);
    slv_act = en & ~master_select & ~s.ss_s2;
    ledge = 1'b0;
    tedge = 1'b0;
    in_bit = 1'b0;
    if (en && master_select && s.eng == SPM_RUN) begin
      in_bit = pin_i.miso;
      if (s.divcnt == half_m1) begin
        next_s.divcnt = 7'h00;
        next_s.sck = ~s.sck;
        ledge = (s.sck == cpol);
        tedge = ~ledge;
      end else begin
        next_s.divcnt = 7'(s.divcnt + 7'h01);
      end
    end else if (slv_act) begin
      // Rate bits play no part here; timing comes from the external clock
      in_bit = pin_i.mosi;
      ledge = cpol ? (~s.sck_s2 & s.sck_s3) : (s.sck_s2 & ~s.sck_s3);
      tedge = cpol ? (s.sck_s2 & ~s.sck_s3) : (~s.sck_s2 & s.sck_s3);
    end
    samp = cpha ? tedge : ledge;
    setup = cpha ? ledge : tedge;
    cnt = s.bitcnt;
    if (samp) begin
      next_s.sr = shift_in(s.sr, in_bit, lsb);
      cnt = 4'(s.bitcnt + 4'h1);
    end
    if (setup) begin
      next_s.dout = out_bit(s.sr, lsb);
    end
    next_s.bitcnt = cnt;
    // Master ends after the eighth trailing edge, slave at the eighth sample
    if (cnt == BYTE_BITS && ((master_select && tedge) || (!master_select && samp))) begin
      next_s.bitcnt = 4'h0;
      next_s.eng = SPM_IDLE;
      // Overwrites an unread byte; receive holds only one finished byte
      next_s.rxbuf = next_s.sr;
      next_s.done_flag = 1'b1;
    end
    // Select released: drop the byte in flight
    if (en && !master_select && s.ss_s2 && !s.ss_s3) begin
      next_s.bitcnt = 4'h0;
      next_s.sr = 8'h00;
      next_s.dout = 1'b0;
    end
    // Another master pulled select low while it is an input
    if (en && master_select && !s.pdir[PIN_SS_OUT] && !s.ss_s2) begin
      next_s.ctrl[CTRL_MASTER_SELECT] = 1'b0;
      next_s.eng = SPM_IDLE;
      next_s.bitcnt = 4'h0;
      next_s.done_flag = 1'b1;
    end
    if (!en) begin
      next_s.eng = SPM_IDLE;
      next_s.bitcnt = 4'h0;
    end
    if (next_s.eng == SPM_IDLE) begin
      next_s.sck = next_s.ctrl[CTRL_CPOL];
    end
    // Collision set last so it wins over a clear in the same cycle
    if (wr && wb_i.adr == ADR_DATA && busy) begin
      next_s.write_collision_flag_flag = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.dat};
  assign irq_o = s.ctrl[CTRL_IE] & s.done_flag & gie_i;

  assign pin_o.sck = s.sck;
  assign pin_o.mosi = s.dout;
  assign pin_o.miso = s.dout;
  assign pin_o.ss = s.pdir[PIN_SS_LEVEL];

  // Master pins go input as soon as the master bit drops
  assign pin_oe_o.mosi = s.ctrl[CTRL_EN] & s.ctrl[CTRL_MASTER_SELECT] & s.pdir[PIN_MOSI_OUT];
  assign pin_oe_o.sck = s.ctrl[CTRL_EN] & s.ctrl[CTRL_MASTER_SELECT] & s.pdir[PIN_SCK_OUT];
  assign pin_oe_o.miso = s.ctrl[CTRL_EN] & ~s.ctrl[CTRL_MASTER_SELECT] & ~s.ss_s2 & s.pdir[PIN_MISO_OUT];
  assign pin_oe_o.ss = s.pdir[PIN_SS_OUT] & ~(s.ctrl[CTRL_EN] & ~s.ctrl[CTRL_MASTER_SELECT]);

endmodule

// *** spm_pkg.sv ***
// Constants, register map and carrier types for the serial peripheral port
package spm_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic [7:0] ADR_PINS = 8'h0C;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_IE = 7;
  localparam int CTRL_EN = 6;
  localparam int CTRL_LSB = 5;
  localparam int CTRL_MASTER_SELECT = 4;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_CPHA = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;

  // Status register fields
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_DBL = 0;

  // Pin configuration register fields
  localparam int PIN_MOSI_OUT = 0;
  localparam int PIN_MISO_OUT = 1;
  localparam int PIN_SCK_OUT = 2;
  localparam int PIN_SS_OUT = 3;
  localparam int PIN_SS_LEVEL = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] PINS_RST = 5'h00;

  // ==========================================================================
  // Master clock divisors per rate code, normal and double rate
  localparam logic [7:0] DIV_NORM [4] = '{8'h04, 8'h10, 8'h40, 8'h80};
  localparam logic [7:0] DIV_DBL [4] = '{8'h02, 8'h08, 8'h20, 8'h40};
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ==========================================================================
  // Types
  typedef enum logic {SPM_IDLE, SPM_RUN} spm_eng_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } spm_wb_req_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spm_pins_t;

  typedef struct packed {
    spm_eng_t eng;
    logic [7:0] ctrl;
    logic dbl;
    logic [4:0] pdir;
    logic done_flag;
    logic write_collision_flag_flag;
    logic done_seen;
    logic write_collision_flag_seen;
    logic [7:0] sr;
    logic [7:0] rxbuf;
    logic dout;
    logic sck;
    logic [3:0] bitcnt;
    logic [6:0] divcnt;
    logic ss_s1;
    logic ss_s2;
    logic ss_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic ack;
    logic [7:0] dat;
  } spm_state_t;

endpackage

// *** spm_port_asserts.sv ***
// Port-level checks for the serial port
`timescale 1ns/10ps
module spm_port_asserts
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus and interrupt
  input wire spm_wb_req_t wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic gie_i,
  input wire logic irq_ack_i,
  input wire logic irq_o,
  // Serial pins
  input wire spm_pins_t pin_i,
  input wire spm_pins_t pin_o,
  input wire spm_pins_t pin_oe_o
);
  // ======
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Select held long enough to cover the two-flop synchroniser lag
  sequence ss_low_held; (!pin_i.ss && !pin_oe_o.ss) [*5]; endsequence
  sequence ss_high_held; pin_i.ss [*4]; endsequence
  AST_ACK_LAT: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
  AST_ROLE_EXCL: assert property (!(pin_oe_o.miso && (pin_oe_o.mosi || pin_oe_o.sck)))
    else $error("roles mixed");
  AST_SS_LOSS: assert property (ss_low_held |-> !pin_oe_o.mosi && !pin_oe_o.sck) else $error("master kept");
  AST_SLV_IDLE: assert property (ss_high_held |-> !pin_oe_o.miso) else $error("miso driven");
  AST_IRQ_GIE: assert property (irq_o |-> gie_i) else $error("irq unmasked");
  AST_IRQ_CLR: assert property (irq_ack_i |=> !irq_o) else $error("irq kept");
endmodule

bind spm_port spm_port_asserts spm_port_asserts_inst (.clk_i, .rst_i, .wb_i, .wb_ack_o, .wb_dat_o, .gie_i,
  .irq_ack_i, .irq_o, .pin_i, .pin_o, .pin_oe_o);

// *** spm_slave_model.sv ***
// Behavioural serial slave answering the port in master role
`timescale 1ns/10ps
module spm_slave_model (
  // Serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  output logic miso_o,
  // Mode and data
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sh;
  initial begin
    miso_o = 1'b0;
    rx_o = 8'h00;
    sh = 8'h00;
  end
  // Released line flips so a stale bit never reads as valid
  always @(posedge cs_n_i) miso_o = ~miso_o;
  always @(negedge cs_n_i) begin
    sh = tx_i;
    if (!cpha_i) miso_o = sh[7];
  end
  always @(sck_i) begin
    if (!cs_n_i && ((sck_i != cpol_i) != cpha_i)) rx_o = {rx_o[6:0], mosi_i};
    else if (!cs_n_i && cpha_i) begin
      miso_o = sh[7];
      sh = sh << 1;
    end else if (!cs_n_i) begin
      sh = sh << 1;
      miso_o = sh[7];
    end
  end
endmodule

// *** spm_port_test.sv ***
// Self-checking bench for the serial port
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module spm_port_test;
  import spm_pkg::*;
  logic clk_i = 0, rst_i = 1, gie_i = 0, irq_ack_i = 0;
  spm_wb_req_t req = '0;
  logic wb_ack_o, irq_o, smiso;
  logic [31:0] wb_dat_o, e32;
  spm_pins_t pin_i, pin_o, pin_oe_o;
  logic ms = 1, mk = 0, md = 0, cpol = 0, cpha = 0;
  logic [7:0] stx = 0, srx, b, c, g;
  logic [31:0] q[$];
  int n_mismatch = 0, n_compared = 0, t, d;
  always #5 clk_i = ~clk_i;
  // Each wire takes its level from whichever side enables a driver
  assign pin_i.sck = pin_oe_o.sck ? pin_o.sck : mk;
  assign pin_i.mosi = pin_oe_o.mosi ? pin_o.mosi : md;
  assign pin_i.miso = pin_oe_o.miso ? pin_o.miso : smiso;
  assign pin_i.ss = pin_oe_o.ss ? pin_o.ss : ms;
  spm_port spm_port_inst (.clk_i, .rst_i, .wb_i(req), .wb_ack_o, .wb_dat_o, .gie_i, .irq_ack_i, .irq_o,
    .pin_i, .pin_o, .pin_oe_o);
  spm_slave_model spm_slave_model_inst (.sck_i(pin_i.sck), .mosi_i(pin_i.mosi), .cs_n_i(pin_i.ss),
    .miso_o(smiso), .cpol_i(cpol), .cpha_i(cpha), .tx_i(stx), .rx_o(srx));
  // ======
  // Tasks
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, v}};
    // Request stands until the rising edge that samples ack high
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++k < 50);
    if (k >= 50) n_mismatch++;
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do @(negedge clk_i); while (irq_o !== 1'b1 && ++n < 3000);
  endtask
  // External master: five cycles per clock phase, mode 0, msb first
  task automatic sbyte(input logic [7:0] v, input int n, output logic [7:0] got);
    for (int i = 7; i > 7 - n; i--) begin
      md <= v[i];
      repeat (5) @(posedge clk_i);
      mk <= 1'b1;
      got[i] = pin_i.miso;
      repeat (5) @(posedge clk_i);
      mk <= 1'b0;
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk_i) if (wb_ack_o === 1'b1 && req.we === 1'b0) begin
    e32 = q.pop_front();
    `CHK("read data", e32, wb_dat_o)
  end
  initial begin
    #200_000;
    n_mismatch++;
    end_of_test();
  end
  // ======
  // Scenarios
  initial begin
    void'($urandom(32'h075F5C39));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    gie_i <= 1'b1;
    rd(ADR_STAT, 8'h00);
    rd(8'h10, 8'h00);
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} <= m[1:0];
      stx <= 8'($urandom);
      b = 8'($urandom);
      wb(1, ADR_PINS, 8'h1D);
      wb(1, ADR_STAT, {7'h0, m[0]});
      wb(1, ADR_CTRL, {2'b11, m == 2, 1'b1, m[1:0], m[1:0]});
      wb(1, ADR_PINS, 8'h0D);
      wb(1, ADR_DATA, b);
      if (m == 1) wb(1, ADR_DATA, ~b);
      wait_irq(t);
      d = m[0] ? DIV_DBL[m] : DIV_NORM[m];
      `CHK("sck timing", 8 * d - 1 - (m == 1 ? 3 : 0), t)
      `CHK("slave rx", m == 2 ? rev(b) : b, srx)
      rd(ADR_STAT, {1'b1, m == 1, 5'h0, m[0]});
      rd(ADR_DATA, m == 2 ? rev(stx) : stx);
      rd(ADR_STAT, {7'h0, m[0]});
    end
    // Raise the driven select first so handing the pin back to ms makes no false low
    wb(1, ADR_PINS, 8'h1D);
    wb(1, ADR_PINS, 8'h05);
    wb(1, ADR_CTRL, 8'hD0);
    ms <= 1'b0;
    wait_irq(t);
    rd(ADR_CTRL, 8'hC0);
    rd(ADR_STAT, 8'h81);
    @(posedge clk_i) irq_ack_i <= 1'b1;
    @(posedge clk_i) irq_ack_i <= 1'b0;
    rd(ADR_STAT, 8'h01);
    ms <= 1'b1;
    wb(1, ADR_PINS, 8'h02);
    wb(1, ADR_CTRL, 8'h40);
    ms <= 1'b0;
    sbyte(8'($urandom), 3, g);
    ms <= 1'b1;
    repeat (5) @(posedge clk_i);
    b = 8'($urandom);
    c = 8'($urandom);
    wb(1, ADR_DATA, b);
    ms <= 1'b0;
    sbyte(c, 8, g);
    ms <= 1'b1;
    `CHK("miso byte", b, g)
    rd(ADR_STAT, 8'h81);
    rd(ADR_DATA, c);
    end_of_test();
  end
endmodule
